/* rtl/mtl_core.sv */
// MAC table learning, aging, atomic CPU access and parity handling
//
// Local design decisions: the Wishbone register port and the register addresses.
`timescale 1ns/10ps
module mtl_core import mtl_pkg::*; #(
	parameter int PORTS = 24,
	parameter int ENTRIES = 16,
	parameter int AGE_SHIFT = 16,
	parameter int BE_RATIO = 4,
	parameter int EVT_DEPTH = 64
)(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	input wire logic wb_we_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	output logic wb_ack_o,
	input wire logic lrn_valid_i,
	output logic lrn_ready_o,
	input wire logic [PORT_W-1:0] lrn_port_i,
	input wire logic [MAC_W-1:0] lrn_mac_i,
	input wire logic [VID_W-1:0] lrn_vid_i,
	input wire logic load_high_i,
	input wire logic frm_end_i,
	input wire logic frm_rx_crc_ok_i,
	input wire logic frm_tx_crc_bad_i,
	input wire logic frm_par_err_i,
	output logic force_bad_crc_o,
	input wire logic sch_par_fatal_i,
	input wire logic sch_par_leak_i,
	input wire logic vlan_par_err_i,
	input wire logic [VID_W-1:0] vlan_par_vid_i,
	input wire logic [VID_W-1:0] frm_vid_i,
	output logic vlan_discard_o,
	output logic irq_o
);
	localparam int IW = $clog2(ENTRIES);
	localparam int BW = $clog2(BE_RATIO) + 1;

	typedef enum logic {ST_RUN, ST_SWEEP} mtl_state_t;

	logic [DW-1:0] tw0 [ENTRIES];
	logic [DW-1:0] tw1 [ENTRIES];
	logic [DW-1:0] tw2 [ENTRIES];
	logic [PORTS-1:0] learn_en_reg;
	logic [DW-1:0] age_cfg_reg;
	logic [STAT_W-1:0] stk_reg;
	logic [STAT_W-1:0] stk_next;
	logic [STAT_W-1:0] stk_set;
	logic [STAT_W-1:0] stat_view;
	logic [STAT_W-1:0] irq_mask_reg;
	logic [CTRL_W-1:0] ctrl_reg;
	logic [IW-1:0] tbl_idx_reg;
	logic [DW-1:0] c0_reg;
	logic [DW-1:0] c1_reg;
	logic [DW-1:0] c2_reg;
	logic [DW-1:0] fm_cnt_reg;
	logic vbad_v_reg;
	logic [VID_W-1:0] vbad_vid_reg;
	logic bad_crc_reg;
	logic ack_reg;
	logic [DW-1:0] dat_reg;
	logic [DW-1:0] rdata;
	mtl_state_t state_reg;
	logic [IW-1:0] sw_idx_reg;
	logic [47:0] age_cnt_reg;
	logic [47:0] age_raw;
	logic [47:0] age_thr;
	logic [BW-1:0] be_cnt_reg;
	logic acc;
	logic wr;
	logic rd;
	logic commit;
	logic rd_evt;
	logic lrn_take;
	logic port_en;
	logic be_skip;
	logic lrn_do;
	logic hit;
	logic free;
	logic perr;
	logic [IW-1:0] hit_idx;
	logic [IW-1:0] free_idx;
	logic [DW-1:0] key1;
	logic [DW-1:0] tw0_sel;
	logic [DW-1:0] sw2;
	logic sw_ok;
	logic sw_bad;
	logic evt_push;
	logic [REC_W-1:0] evt_rec;
	logic push_ready;
	logic pop_valid;
	logic [REC_W-1:0] pop_data;
	logic fm_evt;

	function automatic logic line_ok(input logic [DW-1:0] w0, input logic [DW-1:0] w1,
		input logic [DW-1:0] w2);
		line_ok = w2[W2_VALID] && (mtl_par(w0, w1, w2) == w2[W2_PAR]);
	endfunction

	// ************************************************************
	// Wishbone slave
	// ************************************************************
	assign acc = wb_cyc_i & wb_stb_i & ~ack_reg;
	assign wr = acc & wb_we_i;
	assign rd = acc & ~wb_we_i;
	assign commit = wr && (wb_adr_i == A_TBL_W2);
	assign rd_evt = rd && (wb_adr_i == A_EVT);
	assign wb_ack_o = ack_reg;
	assign wb_dat_o = dat_reg;
	assign tw0_sel = tw0[tbl_idx_reg];
	assign stat_view = {stk_reg[STAT_W-1:S_EVT+1], pop_valid};

	always_comb
	begin
		rdata = '0;
		if (wb_adr_i == A_LEARN_EN)
			rdata = DW'(learn_en_reg);
		else if (wb_adr_i == A_AGE_CFG)
			rdata = age_cfg_reg;
		else if (wb_adr_i == A_STATUS)
			rdata = DW'(stat_view);
		else if (wb_adr_i == A_IRQ_MASK)
			rdata = DW'(irq_mask_reg);
		else if (wb_adr_i == A_EVT)
			rdata = pop_valid ? {pop_valid, pop_data} : '0; // Empty queue storage is never shown
		else if (wb_adr_i == A_FM_CNT)
			rdata = fm_cnt_reg;
		else if (wb_adr_i == A_TBL_IDX)
			rdata = DW'(tbl_idx_reg);
		else if (wb_adr_i == A_TBL_W0)
			rdata = tw0_sel;
		else if (wb_adr_i == A_TBL_W1)
			rdata = c1_reg;
		else if (wb_adr_i == A_TBL_W2)
			rdata = c2_reg;
		else if (wb_adr_i == A_VLAN_BAD)
			rdata = {vbad_v_reg, 19'h0, vbad_vid_reg};
		else if (wb_adr_i == A_CTRL)
			rdata = DW'(ctrl_reg);
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			ack_reg <= 1'b0;
			dat_reg <= '0;
		end
		else
		begin
			ack_reg <= acc;
			if (rd)
				dat_reg <= rdata;
		end
	end

	// Learning enables per port, global aging config and control
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			learn_en_reg <= '0;
			age_cfg_reg <= '0;
			irq_mask_reg <= '0;
			ctrl_reg <= '0;
			tbl_idx_reg <= '0;
		end
		else if (wr)
		begin
			if (wb_adr_i == A_LEARN_EN)
				learn_en_reg <= PORTS'(mtl_merge(DW'(learn_en_reg), wb_dat_i, wb_sel_i));
			else if (wb_adr_i == A_AGE_CFG)
				age_cfg_reg <= mtl_merge(age_cfg_reg, wb_dat_i, wb_sel_i);
			else if (wb_adr_i == A_IRQ_MASK)
				irq_mask_reg <= STAT_W'(mtl_merge(DW'(irq_mask_reg), wb_dat_i, wb_sel_i));
			else if (wb_adr_i == A_CTRL)
				ctrl_reg <= CTRL_W'(mtl_merge(DW'(ctrl_reg), wb_dat_i, wb_sel_i));
			else if (wb_adr_i == A_TBL_IDX)
				tbl_idx_reg <= IW'(mtl_merge(DW'(tbl_idx_reg), wb_dat_i, wb_sel_i));
		end
	end

	// ************************************************************
	// Line cache
	// ************************************************************
	// Words 0 and 1 stage in the cache so that a partial update never reaches the table
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			c0_reg <= '0;
			c1_reg <= '0;
			c2_reg <= '0;
		end
		else if (rd && wb_adr_i == A_TBL_W0)
		begin
			c0_reg <= tw0_sel;
			c1_reg <= tw1[tbl_idx_reg];
			c2_reg <= tw2[tbl_idx_reg];
		end
		else if (wr && wb_adr_i == A_TBL_W0)
			c0_reg <= mtl_merge(c0_reg, wb_dat_i, wb_sel_i);
		else if (wr && wb_adr_i == A_TBL_W1)
			c1_reg <= mtl_merge(c1_reg, wb_dat_i, wb_sel_i);
		else if (commit)
			c2_reg <= mtl_merge(c2_reg, wb_dat_i, wb_sel_i);
	end

	// ************************************************************
	// Source lookup and learning
	// ************************************************************
	assign key1 = mtl_key(lrn_vid_i, lrn_mac_i);
	assign lrn_ready_o = (state_reg == ST_RUN) && !commit;
	assign lrn_take = lrn_valid_i & lrn_ready_o;
	assign port_en = (int'(lrn_port_i) < PORTS) && learn_en_reg[lrn_port_i];
	// Under load only one lookup in BE_RATIO is performed
	assign be_skip = ctrl_reg[C_BEST] && load_high_i && (be_cnt_reg != '0);
	assign lrn_do = lrn_take && port_en && !be_skip;

	always_comb
	begin
		hit = 1'b0;
		free = 1'b0;
		perr = 1'b0;
		hit_idx = '0;
		free_idx = '0;
		for (int i = 0; i < ENTRIES; i++)
		begin
			if (tw2[i][W2_VALID] && !line_ok(tw0[i], tw1[i], tw2[i]))
				perr = 1'b1;
			if (line_ok(tw0[i], tw1[i], tw2[i]))
			begin
				if (!hit && tw0[i] == lrn_mac_i[DW-1:0] && tw1[i] == key1)
				begin
					hit = 1'b1;
					hit_idx = IW'(i);
				end
			end
			else if (!free)
			begin
				free = 1'b1;
				free_idx = IW'(i);
			end
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			be_cnt_reg <= '0;
		else if (lrn_take && ctrl_reg[C_BEST] && load_high_i)
			be_cnt_reg <= (be_cnt_reg == BW'(BE_RATIO - 1)) ? '0 : BW'(be_cnt_reg + 1'b1);
	end

	// ************************************************************
	// Aging
	// ************************************************************
	assign age_raw = 48'(age_cfg_reg) << AGE_SHIFT;
	always_comb
	begin
		age_thr = age_raw;
		if (age_raw <= AGE_MIN_CYC)
			age_thr = 48'(AGE_MIN_CYC + 1'b1);
		else if (age_raw >= AGE_MAX_CYC)
			age_thr = 48'(AGE_MAX_CYC - 1'b1);
	end

	assign sw2 = tw2[sw_idx_reg];
	assign sw_ok = line_ok(tw0[sw_idx_reg], tw1[sw_idx_reg], sw2);
	assign sw_bad = sw2[W2_VALID] && !sw_ok;

	// Zero config means no aging; a new config restarts the period
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			state_reg <= ST_RUN;
			sw_idx_reg <= '0;
			age_cnt_reg <= '0;
		end
		else
		begin
			case (state_reg)
				ST_RUN:
				begin
					if (age_cfg_reg == '0 || (wr && wb_adr_i == A_AGE_CFG))
						age_cnt_reg <= '0;
					else if (age_cnt_reg >= age_thr - 1'b1)
					begin
						age_cnt_reg <= '0;
						sw_idx_reg <= '0;
						state_reg <= ST_SWEEP;
					end
					else
						age_cnt_reg <= 48'(age_cnt_reg + 1'b1);
				end
				ST_SWEEP:
				begin
					if (!commit)
					begin
						sw_idx_reg <= IW'(sw_idx_reg + 1'b1);
						if (sw_idx_reg == IW'(ENTRIES - 1))
							state_reg <= ST_RUN;
					end
				end
				default: state_reg <= ST_RUN;
			endcase
		end
	end

	// ************************************************************
	// Table storage
	// ************************************************************
	// Priority: CPU commit, then aging sweep, then hardware learning
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			for (int i = 0; i < ENTRIES; i++)
			begin
				tw0[i] <= '0;
				tw1[i] <= '0;
				tw2[i] <= '0;
			end
		end
		else if (commit)
		begin
			tw0[tbl_idx_reg] <= c0_reg;
			tw1[tbl_idx_reg] <= c1_reg;
			tw2[tbl_idx_reg] <= mtl_seal(c0_reg, c1_reg, mtl_merge(c2_reg, wb_dat_i, wb_sel_i))
				^ DW'(ctrl_reg[C_BADPAR]);
		end
		else if (state_reg == ST_SWEEP)
		begin
			if (sw_ok && !sw2[W2_LOCK])
			begin
				if (sw2[W2_AGE])
					tw2[sw_idx_reg] <= mtl_seal(tw0[sw_idx_reg], tw1[sw_idx_reg],
						sw2 & ~(DW'(1) << W2_VALID));
				else
					tw2[sw_idx_reg] <= mtl_seal(tw0[sw_idx_reg], tw1[sw_idx_reg],
						sw2 | (DW'(1) << W2_AGE));
			end
		end
		else if (lrn_do && hit && !tw2[hit_idx][W2_LOCK])
		begin
			tw2[hit_idx] <= mtl_seal(tw0[hit_idx], tw1[hit_idx],
				{tw2[hit_idx][W2_VALID], 1'b0, 1'b0, tw2[hit_idx][W2_AGE-1:W2_PORT+PORT_W],
				lrn_port_i, tw2[hit_idx][W2_PORT-1:0]});
		end
		else if (lrn_do && !hit && free)
		begin
			tw0[free_idx] <= lrn_mac_i[DW-1:0];
			tw1[free_idx] <= key1;
			tw2[free_idx] <= mtl_seal(lrn_mac_i[DW-1:0], key1,
				(DW'(1) << W2_VALID) | (DW'(lrn_port_i) << W2_PORT));
		end
	end

	// ************************************************************
	// Change queue
	// ************************************************************
	always_comb
	begin
		evt_push = 1'b0;
		evt_rec = '0;
		if (state_reg == ST_SWEEP)
		begin
			if (!commit && sw_ok && !sw2[W2_LOCK] && sw2[W2_AGE])
			begin
				evt_push = 1'b1;
				evt_rec = mtl_rec(EVT_AGE, sw2[W2_PORT +: PORT_W], RIDX_W'(sw_idx_reg),
					tw1[sw_idx_reg][VID_W+15:16]);
			end
		end
		else if (lrn_do && hit && !tw2[hit_idx][W2_LOCK]
			&& tw2[hit_idx][W2_PORT +: PORT_W] != lrn_port_i)
		begin
			evt_push = 1'b1;
			evt_rec = mtl_rec(EVT_LEARN, lrn_port_i, RIDX_W'(hit_idx), lrn_vid_i);
		end
		else if (lrn_do && !hit && free)
		begin
			evt_push = 1'b1;
			evt_rec = mtl_rec(EVT_LEARN, lrn_port_i, RIDX_W'(free_idx), lrn_vid_i);
		end
	end

	mtl_evt_fifo #(
		.WIDTH(REC_W),
		.DEPTH(EVT_DEPTH)
	) u_evt_fifo (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.in_valid_i(evt_push),
		.in_ready_o(push_ready),
		.in_data_i(evt_rec),
		.out_valid_o(pop_valid),
		.out_ready_i(rd_evt),
		.out_data_o(pop_data)
	);

	// ************************************************************
	// Error reporting, status and interrupt
	// ************************************************************
	assign fm_evt = frm_end_i && frm_rx_crc_ok_i && frm_tx_crc_bad_i;

	// Detection only; nothing here repairs a bad line
	always_comb
	begin
		stk_set = '0;
		stk_set[S_OVF] = evt_push && !push_ready;
		stk_set[S_TPAR] = (lrn_do && perr) || (state_reg == ST_SWEEP && sw_bad);
		stk_set[S_VPAR] = vlan_par_err_i;
		stk_set[S_SFATAL] = sch_par_fatal_i;
		stk_set[S_SLEAK] = sch_par_leak_i;
		stk_set[S_FMERR] = fm_evt;
		stk_next = stk_reg;
		if (wr && wb_adr_i == A_STATUS)
			stk_next = stk_reg & ~STAT_W'(wb_dat_i & {{24{1'b0}}, {8{wb_sel_i[0]}}});
		// A new event in the clearing cycle is kept
		stk_next = stk_next | stk_set;
		stk_next[S_EVT] = 1'b0;
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			stk_reg <= '0;
		else
			stk_reg <= stk_next;
	end

	assign irq_o = |(stat_view & irq_mask_reg);

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			fm_cnt_reg <= '0;
		else if (fm_evt)
			fm_cnt_reg <= DW'(fm_cnt_reg + 1'b1);
	end

	// Frame held with a forced bad CRC until its end; cut-through or not alike
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			bad_crc_reg <= 1'b0;
		else if (frm_par_err_i)
			bad_crc_reg <= 1'b1;
		else if (frm_end_i)
			bad_crc_reg <= 1'b0;
	end
	assign force_bad_crc_o = bad_crc_reg;

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			vbad_v_reg <= 1'b0;
			vbad_vid_reg <= '0;
		end
		else if (vlan_par_err_i)
		begin
			vbad_v_reg <= 1'b1;
			vbad_vid_reg <= vlan_par_vid_i;
		end
		else if (wr && wb_adr_i == A_VLAN_BAD)
			vbad_v_reg <= 1'b0;
	end
	assign vlan_discard_o = vbad_v_reg && (frm_vid_i == vbad_vid_reg);

	// ************************************************************
	// Assertions
	// ************************************************************
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);

	property p_learn_off;
		(lrn_take && !port_en && state_reg == ST_RUN) |-> !evt_push;
	endproperty
	a_learn_off: assert property (p_learn_off) else $error("learn on disabled port");

	property p_age_lock;
		(state_reg == ST_SWEEP && sw2[W2_LOCK]) |-> !evt_push;
	endproperty
	a_age_lock: assert property (p_age_lock) else $error("locked entry aged");

	property p_age_min;
		(age_cfg_reg != '0) |-> (age_thr > AGE_MIN_CYC) && (age_thr < AGE_MAX_CYC);
	endproperty
	a_age_min: assert property (p_age_min) else $error("age period out of range");

	property p_new_evt;
		(lrn_do && !hit && free && state_reg == ST_RUN) |-> evt_push ##1 stat_view[S_EVT];
	endproperty
	a_new_evt: assert property (p_new_evt) else $error("learn event lost");

	property p_ovf;
		(evt_push && !push_ready) |=> stk_reg[S_OVF];
	endproperty
	a_ovf: assert property (p_ovf) else $error("overflow not flagged");

	property p_cache;
		(rd && wb_adr_i == A_TBL_W0) |=> c0_reg == $past(tw0_sel);
	endproperty
	a_cache: assert property (p_cache) else $error("cache not loaded");

	property p_commit;
		commit |=> tw0_sel == $past(c0_reg) && tw1[tbl_idx_reg] == $past(c1_reg);
	endproperty
	a_commit: assert property (p_commit) else $error("line not committed");

	property p_fm;
		fm_evt |=> fm_cnt_reg == $past(fm_cnt_reg) + 1'b1;
	endproperty
	a_fm: assert property (p_fm) else $error("frame error not counted");

	property p_crc;
		frm_par_err_i |=> force_bad_crc_o;
	endproperty
	a_crc: assert property (p_crc) else $error("bad CRC not forced");

	property p_vlan;
		vlan_par_err_i |=> vbad_v_reg && vbad_vid_reg == $past(vlan_par_vid_i);
	endproperty
	a_vlan: assert property (p_vlan) else $error("VLAN entry not invalidated");
endmodule

/* rtl/mtl_pkg.sv */
// Constants, field layout and helper functions of the MAC table learn/age block
package mtl_pkg;
	// Overview of operation
	// - Each port has its own learning enable
	// - Disabled port never inserts table entries
	// - Enabled port inserts after source lookup
	// - Aging uses one table-wide config register
	// - Aging removes only unlocked dynamic entries
	// - Age period above 32000 cycles, or off
	// - Learn/age change readable, maskable interrupt
	// - Change records queue 64 deep
	// - Queue may overflow; software resyncs table
	// - Best-effort mode thins source lookups
	// - Learning and aging never touch locked entries; learning reuses a locked line with a parity error as a free line
	// - Three-word entry access looks atomic
	// - Low word read loads line cache
	// - Top word write commits whole line
	// - Parity errors never corrected, only reported
	// - Good rx CRC, bad tx CRC counted
	// - Frame memory parity error forces bad CRC
	// - Scheduler parity errors: fatal or leak
	// - Table parity error line treated invalid
	// - VLAN parity error discards that VLAN

	// ************************************************************
	// Register map and fields
	// ************************************************************
	localparam int DW = 32;
	localparam logic [7:0] A_LEARN_EN = 8'h00;
	localparam logic [7:0] A_AGE_CFG = 8'h04;
	localparam logic [7:0] A_STATUS = 8'h08;
	localparam logic [7:0] A_IRQ_MASK = 8'h0C;
	localparam logic [7:0] A_EVT = 8'h10;
	localparam logic [7:0] A_FM_CNT = 8'h14;
	localparam logic [7:0] A_TBL_IDX = 8'h18;
	localparam logic [7:0] A_TBL_W0 = 8'h1C;
	localparam logic [7:0] A_TBL_W1 = 8'h20;
	localparam logic [7:0] A_TBL_W2 = 8'h24;
	localparam logic [7:0] A_VLAN_BAD = 8'h28;
	localparam logic [7:0] A_CTRL = 8'h2C;

	localparam int STAT_W = 7;
	localparam int S_EVT = 0;
	localparam int S_OVF = 1;
	localparam int S_TPAR = 2;
	localparam int S_VPAR = 3;
	localparam int S_SFATAL = 4;
	localparam int S_SLEAK = 5;
	localparam int S_FMERR = 6;

	localparam int C_BADPAR = 0;
	localparam int C_BEST = 1;
	localparam int CTRL_W = 2;

	localparam int W2_VALID = 31;
	localparam int W2_LOCK = 30;
	localparam int W2_AGE = 29;
	localparam int W2_PORT = 4;
	localparam int W2_PAR = 0;
	localparam int PORT_W = 5;
	localparam int VID_W = 12;
	localparam int MAC_W = 48;
	localparam int REC_W = 31;
	localparam int RIDX_W = 8;

	localparam logic [1:0] EVT_LEARN = 2'h1;
	localparam logic [1:0] EVT_AGE = 2'h2;

	// Whole-table age window in CPU clock periods, bounds exclusive
	localparam logic [47:0] AGE_MIN_CYC = 48'h0000_0000_7D00;
	localparam logic [47:0] AGE_MAX_CYC = 48'h3E7B_7718_9800;

	// ************************************************************
	// Helpers
	// ************************************************************
	function automatic logic mtl_par(input logic [DW-1:0] w0, input logic [DW-1:0] w1,
		input logic [DW-1:0] w2);
		mtl_par = ^{w0, w1, w2[DW-1:W2_PAR+1]};
	endfunction

	function automatic logic [DW-1:0] mtl_seal(input logic [DW-1:0] w0,
		input logic [DW-1:0] w1, input logic [DW-1:0] w2);
		mtl_seal = {w2[DW-1:W2_PAR+1], mtl_par(w0, w1, w2)};
	endfunction

	function automatic logic [DW-1:0] mtl_key(input logic [VID_W-1:0] vid,
		input logic [MAC_W-1:0] mac);
		mtl_key = {4'h0, vid, mac[MAC_W-1:DW]};
	endfunction

	function automatic logic [REC_W-1:0] mtl_rec(input logic [1:0] kind,
		input logic [PORT_W-1:0] port, input logic [RIDX_W-1:0] idx,
		input logic [VID_W-1:0] vid);
		mtl_rec = {kind, port, idx, 4'h0, vid};
	endfunction

	function automatic logic [DW-1:0] mtl_merge(input logic [DW-1:0] old,
		input logic [DW-1:0] nw, input logic [3:0] sel);
		for (int b = 0; b < 4; b++)
			mtl_merge[b*8 +: 8] = sel[b] ? nw[b*8 +: 8] : old[b*8 +: 8];
	endfunction
endpackage

/* rtl/mtl_evt_fifo.sv */
// Change-record queue built from flip-flops
`timescale 1ns/10ps
module mtl_evt_fifo #(
	parameter int WIDTH = 31,
	parameter int DEPTH = 64
)(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic in_valid_i,
	output logic in_ready_o,
	input wire logic [WIDTH-1:0] in_data_i,
	output logic out_valid_o,
	input wire logic out_ready_i,
	output logic [WIDTH-1:0] out_data_o
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_reg [DEPTH];
	logic [AW-1:0] wr_reg;
	logic [AW-1:0] rd_reg;
	logic [AW:0] cnt_reg;
	logic push;
	logic pop;

	assign in_ready_o = cnt_reg != (AW+1)'(DEPTH);
	assign out_valid_o = cnt_reg != '0;
	assign out_data_o = mem_reg[rd_reg];
	assign push = in_valid_i & in_ready_o;
	assign pop = out_ready_i & out_valid_o;

	always_ff @(posedge clk_i)
	begin
		if (push)
			mem_reg[wr_reg] <= in_data_i;
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			wr_reg <= '0;
			rd_reg <= '0;
			cnt_reg <= '0;
		end
		else
		begin
			if (push)
				wr_reg <= AW'(wr_reg + 1'b1);
			if (pop)
				rd_reg <= AW'(rd_reg + 1'b1);
			if (push && !pop)
				cnt_reg <= (AW+1)'(cnt_reg + 1'b1);
			else if (pop && !push)
				cnt_reg <= (AW+1)'(cnt_reg - 1'b1);
		end
	end
endmodule

/* tb/mtl_cpu_model.sv */
// Management CPU model issuing classic Wishbone cycles
`timescale 1ns/10ps
module mtl_cpu_model import mtl_pkg::*; (
	input wire logic clk_i,
	output logic [7:0] wb_adr_o,
	output logic [31:0] wb_dat_o,
	input wire logic [31:0] wb_dat_i,
	output logic wb_we_o,
	output logic [3:0] wb_sel_o,
	output logic wb_cyc_o,
	output logic wb_stb_o,
	input wire logic wb_ack_i
);
	initial
	begin
		wb_adr_o = 8'h00;
		wb_dat_o = 32'h0000_0000;
		wb_we_o = 1'b0;
		wb_sel_o = 4'h0;
		wb_cyc_o = 1'b0;
		wb_stb_o = 1'b0;
	end

	// Request held until ack is seen; one idle cycle always follows
	task automatic xfer(input logic we, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q);
		@(posedge clk_i);
		wb_cyc_o <= 1'b1;
		wb_stb_o <= 1'b1;
		wb_we_o <= we;
		wb_adr_o <= a;
		wb_dat_o <= d;
		wb_sel_o <= 4'hF;
		do @(posedge clk_i); while (wb_ack_i !== 1'b1);
		q = wb_dat_i;
		wb_cyc_o <= 1'b0;
		wb_stb_o <= 1'b0;
		wb_we_o <= 1'b0;
	endtask

	// Top word goes last, since it commits the whole cached line
	task automatic put_entry(input logic [31:0] w0, input logic [31:0] w1,
		input logic [31:0] w2);
		logic [31:0] q;
		xfer(1'b1, A_TBL_W0, w0, q);
		xfer(1'b1, A_TBL_W1, w1, q);
		xfer(1'b1, A_TBL_W2, w2, q);
	endtask
endmodule

/* tb/mtl_core_tb.sv */
// Self-checking bench of the MAC table learn/age block
`timescale 1ns/10ps
module mtl_core_tb import mtl_pkg::*;;
	typedef struct packed {logic we; logic [7:0] a; logic [31:0] d; logic [31:0] e;} mtl_row_t;
	logic clk_i = 1'b0, rst_i = 1'b1;
	logic [7:0] adr;
	logic [31:0] wdat, rdat, q;
	logic we, cyc, stb, ack;
	logic [3:0] sel;
	logic lrn_valid = 1'b0, lrn_ready;
	logic [4:0] lrn_port = 5'h00;
	logic [47:0] lrn_mac = 48'h0;
	logic frm_end = 1'b0, rx_ok = 1'b0, tx_bad = 1'b0, fpar = 1'b0;
	logic sfat = 1'b0, sleak = 1'b0, vpar = 1'b0, lh = 1'b0;
	logic [11:0] vvid = 12'h000, fvid = 12'h000;
	logic bad_crc, vdisc, irq;
	int failures = 0, tests_run = 0;
	mtl_row_t rows [0:8] = '{
		'{1'b0, A_STATUS, 32'h0, 32'h0}, '{1'b0, A_EVT, 32'h0, 32'h0},
		'{1'b0, A_AGE_CFG, 32'h0, 32'h0},
		'{1'b1, A_LEARN_EN, 32'h0000_0018, 32'h0},
		'{1'b0, A_LEARN_EN, 32'h0, 32'h0000_0018},
		'{1'b1, A_IRQ_MASK, 32'h0000_007F, 32'h0},
		'{1'b0, A_IRQ_MASK, 32'h0, 32'h0000_007F},
		'{1'b1, 8'h30, 32'hFFFF_FFFF, 32'h0}, '{1'b0, 8'h30, 32'h0, 32'h0}};

	mtl_core #(.ENTRIES(4), .AGE_SHIFT(0)) DUT (.clk_i(clk_i), .rst_i(rst_i),
		.wb_adr_i(adr), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_we_i(we), .wb_sel_i(sel),
		.wb_cyc_i(cyc), .wb_stb_i(stb), .wb_ack_o(ack), .lrn_valid_i(lrn_valid),
		.lrn_ready_o(lrn_ready), .lrn_port_i(lrn_port), .lrn_mac_i(lrn_mac),
		.lrn_vid_i(12'h005), .load_high_i(lh), .frm_end_i(frm_end),
		.frm_rx_crc_ok_i(rx_ok), .frm_tx_crc_bad_i(tx_bad), .frm_par_err_i(fpar),
		.force_bad_crc_o(bad_crc), .sch_par_fatal_i(sfat), .sch_par_leak_i(sleak),
		.vlan_par_err_i(vpar), .vlan_par_vid_i(vvid), .frm_vid_i(fvid),
		.vlan_discard_o(vdisc), .irq_o(irq));
	mtl_cpu_model cpu (.clk_i(clk_i), .wb_adr_o(adr), .wb_dat_o(wdat), .wb_dat_i(rdat),
		.wb_we_o(we), .wb_sel_o(sel), .wb_cyc_o(cyc), .wb_stb_o(stb), .wb_ack_i(ack));

	initial
	begin
		forever #2.5 clk_i = ~clk_i;
	end

	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		tests_run++;
		if (g !== e)
		begin
			failures++;
			$display("MISMATCH %s expected %h seen %h", n, e, g);
		end
	endtask

	task automatic learn(input logic [4:0] p, input logic [47:0] m);
		@(posedge clk_i);
		lrn_port <= p;
		lrn_mac <= m;
		lrn_valid <= 1'b1;
		do @(posedge clk_i); while (lrn_ready !== 1'b1);
		lrn_valid <= 1'b0;
	endtask

	task automatic final_report;
		if (failures == 0 && tests_run > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	// Two full age periods plus margin bound the whole run
	initial
	begin
		repeat (80000) @(posedge clk_i);
		failures++;
		final_report();
	end

	// ************************************************************
	// Main sequence
	// ************************************************************
	initial
	begin
		repeat (5) @(posedge clk_i);
		rst_i <= 1'b0;
		chk("irq", 32'h0, {31'h0, irq});
		chk("bad_crc", 32'h0, {31'h0, bad_crc});
		foreach (rows[i])
		begin
			cpu.xfer(rows[i].we, rows[i].a, rows[i].d, q);
			if (!rows[i].we)
				chk("row", rows[i].e, q);
		end
		cpu.put_entry(32'h89AB_CDEF, 32'h0005_0123, 32'hC000_0070);
		cpu.xfer(1'b0, A_TBL_W0, 32'h0, q);
		chk("w0", 32'h89AB_CDEF, q);
		cpu.xfer(1'b0, A_TBL_W1, 32'h0, q);
		chk("w1", 32'h0005_0123, q);
		cpu.xfer(1'b0, A_TBL_W2, 32'h0, q);
		chk("w2", {31'h6000_0038, ^{64'h89AB_CDEF_0005_0123, 31'h6000_0038}}, q);
		learn(5'd5, 48'h0000_1111_2222);
		cpu.xfer(1'b0, A_STATUS, 32'h0, q);
		chk("off", 32'h0, q);
		learn(5'd3, 48'h0000_3333_4444);
		cpu.xfer(1'b0, A_STATUS, 32'h0, q);
		chk("evt", 32'h1, {31'h0, q[S_EVT]});
		chk("irq", 32'h1, {31'h0, irq});
		cpu.xfer(1'b0, A_EVT, 32'h0, q);
		chk("lrec", 32'h0A3_005, {q[31:24], q[11:0]});
		cpu.xfer(1'b1, A_AGE_CFG, 32'h1, q);
		repeat (64100) @(posedge clk_i);
		cpu.xfer(1'b0, A_EVT, 32'h0, q);
		chk("arec", 32'h0C3_005, {q[31:24], q[11:0]});
		cpu.xfer(1'b1, A_AGE_CFG, 32'h0, q);
		cpu.xfer(1'b0, A_TBL_W0, 32'h0, q);
		cpu.xfer(1'b0, A_TBL_W2, 32'h0, q);
		chk("lock", 32'h3, {30'h0, q[W2_VALID], q[W2_LOCK]});
		for (int i = 0; i < 66; i++)
			learn((i % 2) ? 5'd4 : 5'd3, 48'h0000_5555_6666);
		cpu.xfer(1'b0, A_STATUS, 32'h0, q);
		chk("ovf", 32'h3, {30'h0, q[S_OVF], q[S_EVT]});
		// Best effort under load: first lookup kept, the next one thinned away
		cpu.xfer(1'b1, A_CTRL, 32'h2, q);
		lh <= 1'b1;
		learn(5'd3, 48'h0000_7777_0001);
		learn(5'd3, 48'h0000_7777_0002);
		lh <= 1'b0;
		cpu.xfer(1'b1, A_TBL_IDX, 32'h2, q);
		cpu.xfer(1'b0, A_TBL_W0, 32'h0, q);
		chk("be_keep", 32'h7777_0001, q);
		cpu.xfer(1'b1, A_TBL_IDX, 32'h3, q);
		cpu.xfer(1'b0, A_TBL_W0, 32'h0, q);
		cpu.xfer(1'b0, A_TBL_W2, 32'h0, q);
		chk("be_skip", 32'h0, {31'h0, q[W2_VALID]});
		// Line stored with broken parity is flagged by the next lookup
		cpu.xfer(1'b1, A_CTRL, 32'h1, q);
		cpu.put_entry(32'h0000_9999, 32'h0005_0000, 32'hC000_0030);
		learn(5'd3, 48'h0000_0000_9999);
		@(posedge clk_i);
		fpar <= 1'b1;
		vpar <= 1'b1;
		vvid <= 12'h123;
		fvid <= 12'h123;
		sfat <= 1'b1;
		sleak <= 1'b1;
		@(posedge clk_i);
		fpar <= 1'b0;
		vpar <= 1'b0;
		sfat <= 1'b0;
		sleak <= 1'b0;
		frm_end <= 1'b1;
		rx_ok <= 1'b1;
		tx_bad <= 1'b1;
		#1;
		chk("bad_crc", 32'h1, {31'h0, bad_crc});
		@(posedge clk_i);
		frm_end <= 1'b0;
		#1;
		chk("vdisc", 32'h1, {31'h0, vdisc});
		cpu.xfer(1'b0, A_FM_CNT, 32'h0, q);
		chk("fmcnt", 32'h1, q);
		chk("bad_crc", 32'h0, {31'h0, bad_crc});
		cpu.xfer(1'b0, A_STATUS, 32'h0, q);
		chk("par", 32'h1F, {27'h0, q[6:2]});
		final_report();
	end
endmodule
